// File: logic/eisa_cycle_cfg.svh
`ifndef EISA_CYCLE_CFG_SVH
`define EISA_CYCLE_CFG_SVH
// cycle kinds requested by the local side
`define KIND_BURST    2'h0
`define KIND_NONBURST 2'h1
`define KIND_PEEKPOKE 2'h2
`define KIND_LOCKXCH  2'h3
`define SYNC_DEPTH    2
`endif

// File: logic/eisa_cycle_pkg.sv
`include "eisa_cycle_cfg.svh"
package eisa_cycle_pkg;
    typedef enum logic [1:0] {
        KIND_BURST    = `KIND_BURST,
        KIND_NONBURST = `KIND_NONBURST,
        KIND_PEEKPOKE = `KIND_PEEKPOKE,
        KIND_LOCKXCH  = `KIND_LOCKXCH
    } cycle_kind_t;

    typedef struct packed {
        cycle_kind_t kind;
        logic        write;
        logic        pp_mem;
    } mst_req_t;

    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_ADDR = 5'h02,
        M_STRT = 5'h04,
        M_CMD  = 5'h08,
        M_END  = 5'h10
    } mst_state_t;
endpackage

// File: logic/eisa_cycle_ctrl.sv
`timescale 1ns/1ps
`include "eisa_cycle_cfg.svh"
// Functional notes
// - as master, start low after address and M/IO valid, negate after one BCLK.
// - as slave, start low sampled on rising BCLK marks a slave cycle.
// - on reset start, M/IO and W/R float and act as inputs.
// - as slave, command strobe times internal register accesses.
// - M/IO high means memory, low means I/O; master drives it.
// - master drives M/IO high for burst and two-clock non-burst cycles.
// - peek, poke, locked exchange take M/IO from memory/I/O select bit.
// - as slave, respond to I/O cycles only, never memory.
// - W/R high means write, low read; driven as master, read as slave.
// - master samples ready on falling BCLK after command; low adds wait.
// - as slave, hold ready low until able to complete.
// - master samples 32-bit response on rising edge of start negation.
// - peek/poke and non-burst run 32-bit only; controller converts sizes.
// - as slave, pull 32-bit response low only with 32-bit data.
module eisa_cycle_ctrl
    import eisa_cycle_pkg::*;
(
    input  wire logic                    clk,          // system clock
    input  wire logic                    rst_n,        // async reset
    input  wire logic                    ce,           // clk domain enable
    input  wire logic                    mst_req_valid, // master request
    input  wire eisa_cycle_pkg::mst_req_t mst_req,     // request fields
    output logic                         mst_busy,     // request in flight
    output logic                         mst_done,     // cycle finished pulse
    output logic                         mst_ex32,     // slave was 32-bit
    output logic                         slv_acc,      // slave access pulse
    output logic                         slv_write,    // slave access is write
    input  wire logic                    slv_done,     // local side finished
    input  wire logic                    slv_wide,     // 32-bit data to send
    input  wire logic                    bclk,         // bus clock
    input  wire logic                    slv_hit,      // address decode hit
    input  wire logic                    start_n_i,    // start strobe in
    output logic                         start_n_o,    // start strobe out
    output logic                         start_oe,     // start drive enable
    input  wire logic                    cmd_n_i,      // command strobe
    input  wire logic                    mio_i,        // memory/io in
    output logic                         mio_o,        // memory/io out
    output logic                         mio_oe,       // memory/io enable
    input  wire logic                    wr_i,         // write/read in
    output logic                         wr_o,         // write/read out
    output logic                         wr_oe,        // write/read enable
    input  wire logic                    exrdy_i,      // ready in
    output logic                         exrdy_o,      // ready out, low
    output logic                         exrdy_oe,     // ready pull enable
    input  wire logic                    ex32_n_i,     // 32-bit resp in
    output logic                         ex32_n_o,     // 32-bit resp out
    output logic                         ex32_oe       // 32-bit pull enable
);
    import eisa_cycle_pkg::*;

    // ---------------- clk domain ----------------
    mst_req_t                  hold;
    logic                      req_tgl;
    logic [`SYNC_DEPTH-1:0]    done_sync;
    logic                      done_seen;
    logic [`SYNC_DEPTH-1:0]    acc_sync;
    logic                      acc_seen;
    logic                      ack_tgl;
    // ---------------- bclk domain ---------------
    mst_state_t                st;
    logic [`SYNC_DEPTH-1:0]    req_sync;
    logic                      req_seen;
    logic                      done_tgl;
    logic                      ex32_cap;
    logic                      rdy_fall;
    logic                      s_act;
    logic                      s_wr;
    logic                      acc_tgl;
    logic                      acc_sent;
    logic [`SYNC_DEPTH-1:0]    ack_sync;
    logic                      ack_seen;
    logic                      s_ready;
    logic [`SYNC_DEPTH-1:0]    wide_sync;

    // request accepted only when idle; hold stays stable across the crossing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold     <= '0;
            req_tgl  <= 1'b0;
            mst_busy <= 1'b0;
        end else if (ce) begin
            if (mst_req_valid && !mst_busy) begin
                hold     <= mst_req;
                req_tgl  <= ~req_tgl;
                mst_busy <= 1'b1;
            end else if (done_sync[`SYNC_DEPTH-1] != done_seen) begin
                mst_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_sync <= '0;
            done_seen <= 1'b0;
            mst_done  <= 1'b0;
            mst_ex32  <= 1'b0;
        end else if (ce) begin
            done_sync <= {done_sync[`SYNC_DEPTH-2:0], done_tgl};
            done_seen <= done_sync[`SYNC_DEPTH-1];
            mst_done  <= done_sync[`SYNC_DEPTH-1] != done_seen;
            if (done_sync[`SYNC_DEPTH-1] != done_seen) begin
                mst_ex32 <= ex32_cap; // stable: toggled after capture
            end
        end
    end

    // slave access handed to the local side; slv_done answers it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_sync  <= '0;
            acc_seen  <= 1'b0;
            slv_acc   <= 1'b0;
            slv_write <= 1'b0;
            ack_tgl   <= 1'b0;
        end else if (ce) begin
            acc_sync <= {acc_sync[`SYNC_DEPTH-2:0], acc_tgl};
            acc_seen <= acc_sync[`SYNC_DEPTH-1];
            slv_acc  <= acc_sync[`SYNC_DEPTH-1] != acc_seen;
            if (acc_sync[`SYNC_DEPTH-1] != acc_seen) begin
                slv_write <= s_wr;
            end
            if (slv_done) begin
                ack_tgl <= ~ack_tgl;
            end
        end
    end

    // ---------------- master sequencer ----------------
    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            req_sync <= '0;
        end else begin
            req_sync <= {req_sync[`SYNC_DEPTH-2:0], req_tgl};
        end
    end

    // ready sampled on the falling edge only
    always_ff @(negedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_fall <= 1'b1;
        end else begin
            rdy_fall <= exrdy_i;
        end
    end

    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            st        <= M_IDLE;
            req_seen  <= 1'b0;
            done_tgl  <= 1'b0;
            ex32_cap  <= 1'b0;
            start_n_o <= 1'b1;
            start_oe  <= 1'b0;
            mio_o     <= 1'b0;
            mio_oe    <= 1'b0;
            wr_o      <= 1'b0;
            wr_oe     <= 1'b0;
        end else begin
            case (st)
                M_IDLE: begin
                    // no master cycle while a slave cycle is open
                    if (req_sync[`SYNC_DEPTH-1] != req_seen && !s_act && start_n_i) begin
                        req_seen <= req_sync[`SYNC_DEPTH-1];
                        st       <= M_ADDR;
                        start_oe <= 1'b1;
                        mio_oe   <= 1'b1;
                        wr_oe    <= 1'b1;
                        wr_o     <= hold.write;
                        if (hold.kind == KIND_BURST || hold.kind == KIND_NONBURST) begin
                            mio_o <= 1'b1;
                        end else begin
                            mio_o <= hold.pp_mem;
                        end
                    end
                end
                M_ADDR: begin
                    start_n_o <= 1'b0;
                    st        <= M_STRT;
                end
                M_STRT: begin
                    start_n_o <= 1'b1;
                    ex32_cap  <= !ex32_n_i;
                    st        <= M_CMD;
                end
                M_CMD: begin
                    // 32-bit only: narrow slaves are left to the controller
                    if (rdy_fall) begin
                        st <= M_END;
                    end
                end
                M_END: begin
                    start_oe <= 1'b0;
                    mio_oe   <= 1'b0;
                    wr_oe    <= 1'b0;
                    done_tgl <= ~done_tgl;
                    st       <= M_IDLE;
                end
                default: begin
                    st <= M_IDLE;
                end
            endcase
        end
    end

    // ---------------- slave responder ----------------
    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_sync  <= '0;
            wide_sync <= '0;
        end else begin
            ack_sync  <= {ack_sync[`SYNC_DEPTH-2:0], ack_tgl};
            wide_sync <= {wide_sync[`SYNC_DEPTH-2:0], slv_wide};
        end
    end

    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            s_act    <= 1'b0;
            s_wr     <= 1'b0;
            acc_tgl  <= 1'b0;
            acc_sent <= 1'b0;
            ack_seen <= 1'b0;
            s_ready  <= 1'b0;
            exrdy_o  <= 1'b0;
            exrdy_oe <= 1'b0;
            ex32_n_o <= 1'b0;
            ex32_oe  <= 1'b0;
        end else begin
            if (!s_act) begin
                // only I/O cycles decoded to us open a slave cycle
                if (!start_n_i && !start_oe && !mio_i && slv_hit) begin
                    s_act    <= 1'b1;
                    s_wr     <= wr_i;
                    acc_sent <= 1'b0;
                    s_ready  <= 1'b0;
                    ack_seen <= ack_sync[`SYNC_DEPTH-1];
                    exrdy_oe <= 1'b1;
                    ex32_oe  <= wide_sync[`SYNC_DEPTH-1];
                end
            end else begin
                if (!cmd_n_i && !acc_sent) begin
                    acc_tgl  <= ~acc_tgl;
                    acc_sent <= 1'b1;
                end
                if (ack_sync[`SYNC_DEPTH-1] != ack_seen) begin
                    ack_seen <= ack_sync[`SYNC_DEPTH-1];
                    s_ready  <= 1'b1;
                    exrdy_oe <= 1'b0;
                end
                if (acc_sent && cmd_n_i) begin
                    s_act    <= 1'b0;
                    exrdy_oe <= 1'b0;
                    ex32_oe  <= 1'b0;
                end
            end
        end
    end

    // ---------------- assertions ----------------
    property p_start_one;
        @(posedge bclk) disable iff (!rst_n)
        $fell(start_n_o) |=> start_n_o ##0 $past(start_oe);
    endproperty
    a_start_one: assert property (p_start_one) else $error("start low not one bclk");

    property p_start_after_addr;
        @(posedge bclk) disable iff (!rst_n)
        (start_oe && !start_n_o) |-> mio_oe && $past(mio_oe);
    endproperty
    a_start_after_addr: assert property (p_start_after_addr) else $error("start before M/IO");

    property p_reset_float;
        @(posedge bclk) !rst_n |-> !start_oe && !mio_oe && !wr_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pins driven in reset");

    property p_mem_for_data;
        @(posedge bclk) disable iff (!rst_n)
        (st == M_STRT && (hold.kind == KIND_BURST || hold.kind == KIND_NONBURST))
            |-> mio_o && mio_oe;
    endproperty
    a_mem_for_data: assert property (p_mem_for_data) else $error("data cycle not memory");

    property p_pp_select;
        @(posedge bclk) disable iff (!rst_n)
        (st == M_STRT && hold.kind[1]) |-> mio_o == hold.pp_mem && wr_o == hold.write;
    endproperty
    a_pp_select: assert property (p_pp_select) else $error("peek/poke status wrong");

    property p_io_only;
        @(posedge bclk) disable iff (!rst_n)
        $rose(s_act) |-> $past(!mio_i && !start_n_i);
    endproperty
    a_io_only: assert property (p_io_only) else $error("slave took memory cycle");

    property p_wait_state;
        @(posedge bclk) disable iff (!rst_n)
        (st == M_CMD && !rdy_fall) |=> st == M_CMD;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("wait state skipped");

    property p_hold_off;
        @(posedge bclk) disable iff (!rst_n)
        (s_act && !s_ready && $past(s_act)) |-> exrdy_oe && !exrdy_o;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("ready released early");

    property p_ex32_sample;
        @(posedge bclk) disable iff (!rst_n)
        st == M_STRT |=> ex32_cap == !$past(ex32_n_i);
    endproperty
    a_ex32_sample: assert property (p_ex32_sample) else $error("32-bit sample wrong");

    property p_ex32_slave;
        @(posedge bclk) disable iff (!rst_n)
        ex32_oe |-> s_act && !ex32_n_o;
    endproperty
    a_ex32_slave: assert property (p_ex32_slave) else $error("32-bit driven idle");

    property p_cmd_access;
        @(posedge bclk) disable iff (!rst_n)
        (s_act && !cmd_n_i && !acc_sent) |=> acc_tgl != $past(acc_tgl);
    endproperty
    a_cmd_access: assert property (p_cmd_access) else $error("access not timed");
endmodule

// File: verification/eisa_bus_partner.sv
`timescale 1ns/1ps
module eisa_bus_partner (
    input  wire logic bclk,     // bus clock
    input  wire logic rst_n,    // reset
    input  wire logic start_w,  // start line
    input  wire logic exrdy_w,  // ready line
    output logic      cmd_n,    // command strobe
    output logic      rdy_pull, // pulls ready low
    output wire logic x32_pull, // pulls ex32 low
    output logic      p_oe,     // drives start, mio, wr
    output logic      p_start_n,// start when driving
    output logic      p_mio,    // mio when driving
    output logic      p_wr,     // wr when driving
    output logic      p_hit,    // decode hit
    output logic      pat       // toggles every bclk
);
    int   waits = 0;
    int   cnt = 0;
    logic x32 = 0;
    logic fin = 0;
    initial {p_oe, p_start_n, p_mio, p_wr, p_hit} = 5'h08;
    assign x32_pull = x32 && !p_oe && (!start_w || !cmd_n);
    always @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            {cmd_n, pat} <= 2'h2;
        end else begin
            pat <= !pat;
            if (!start_w && cmd_n) begin
                cmd_n <= 0;
            end else if (fin) begin
                cmd_n <= 1;
            end
        end
    end
    // cycle ends only once every slave lets ready go; one process owns the pull
    always @(negedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            {rdy_pull, fin} <= 2'h0;
            cnt <= 0;
        end else if (!start_w && cmd_n) begin
            rdy_pull <= waits > 0 && !p_oe;
            cnt <= 0;
        end else if (!cmd_n && !fin) begin
            cnt <= cnt + 1;
            rdy_pull <= cnt + 1 < waits;
            fin <= exrdy_w;
        end else begin
            fin <= 0;
        end
    end
    task automatic drive_cycle(input logic mem, input logic wr, input logic hit);
        @(posedge bclk);
        #1 {p_oe, p_mio, p_wr, p_hit} = {1'b1, mem, wr, hit};
        @(posedge bclk);
        #1 p_start_n = 0;
        @(posedge bclk);
        #1 p_start_n = 1;
        @(posedge bclk);
        while (!cmd_n) @(posedge bclk);
        #1 p_oe = 0;
    endtask
endmodule

// File: verification/eisa_cycle_control_signalling_bench.sv
`timescale 1ns/1ps
module eisa_cycle_control_signalling_bench;
    import eisa_cycle_pkg::*;
    logic clk = 0, bclk = 0, rst_n = 1, ce = 1, req_v = 0, s_done = 0, wide = 0;
    mst_req_t req = '0;
    logic busy, m_done, m_ex32, s_acc, s_wr, st_o, st_oe, mio_o, mio_oe, wr_o, wr_oe;
    logic rdy_o, rdy_oe, x_o, x_oe, cmd_n, rdy_pull, x32_pull;
    logic p_oe, p_st, p_mio, p_wr, p_hit, pat, st_w, mio_w, wr_w, rdy_w, x_w;
    int   num_errors = 0, checks_done = 0, oe_cnt, low_cnt, rdy_cnt, cyc = 0;
    logic seen_mio, seen_wr;
    assign st_w  = st_oe ? st_o : (p_oe ? p_st : 1'b1);
    assign mio_w = mio_oe ? mio_o : (p_oe ? p_mio : pat);
    assign wr_w  = wr_oe ? wr_o : (p_oe ? p_wr : !pat);
    assign rdy_w = !(rdy_oe && !rdy_o) && !rdy_pull;
    assign x_w   = !((x_oe && !x_o) || x32_pull);
    eisa_cycle_ctrl u_eisa_cycle_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce),
        .mst_req_valid(req_v), .mst_req(req), .mst_busy(busy), .mst_done(m_done),
        .mst_ex32(m_ex32), .slv_acc(s_acc), .slv_write(s_wr), .slv_done(s_done),
        .slv_wide(wide), .bclk(bclk), .slv_hit(p_oe ? p_hit : pat),
        .start_n_i(st_w), .start_n_o(st_o), .start_oe(st_oe), .cmd_n_i(cmd_n),
        .mio_i(mio_w), .mio_o(mio_o), .mio_oe(mio_oe), .wr_i(wr_w), .wr_o(wr_o),
        .wr_oe(wr_oe), .exrdy_i(rdy_w), .exrdy_o(rdy_o), .exrdy_oe(rdy_oe),
        .ex32_n_i(x_w), .ex32_n_o(x_o), .ex32_oe(x_oe));
    eisa_bus_partner u_eisa_bus_partner (.bclk(bclk), .rst_n(rst_n), .start_w(st_w),
        .exrdy_w(rdy_w), .cmd_n(cmd_n), .rdy_pull(rdy_pull), .x32_pull(x32_pull),
        .p_oe(p_oe), .p_start_n(p_st), .p_mio(p_mio), .p_wr(p_wr), .p_hit(p_hit),
        .pat(pat));
    initial forever #5 clk = !clk;
    initial begin
        #37;
        forever #62.5 bclk = !bclk;
    end
    always @(posedge bclk) begin
        if (mio_oe) oe_cnt++;
        if (rdy_oe) rdy_cnt++;
        if (st_oe && !st_o) begin
            low_cnt++;
            {seen_mio, seen_wr} = {mio_w, wr_w};
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        int   w, acc;
        logic x32, exp_mio, got_w, got_x;
        void'($urandom(32'h4ebedebd));
        // a real falling edge, so the asynchronous resets fire
        #1 rst_n = 0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        repeat (2) @(negedge clk);
        check("oe after reset", {st_oe, mio_oe, wr_oe, rdy_oe, x_oe}, 8'h00);
        for (int i = 0; i < 12; i++) begin
            if (i == 6) begin
                // reset mid-run, held across bus clock edges
                #1 rst_n = 0;
                repeat (30) @(posedge clk);
                check("reset oe", {st_oe, mio_oe, wr_oe, rdy_oe, x_oe, busy}, 8'h00);
                #1 rst_n = 1;
            end
            w = $urandom % 4;
            x32 = $urandom;
            {oe_cnt, low_cnt} = 0;
            u_eisa_bus_partner.waits = w;
            u_eisa_bus_partner.x32 = x32;
            @(posedge clk);
            #1 req_v = 1;
            ce = 0;
            req.kind = cycle_kind_t'(i % 4);
            req.write = $urandom;
            req.pp_mem = $urandom;
            // burst and nonburst always memory, others follow the select bit
            exp_mio = (i % 4 < 2) ? 1'b1 : req.pp_mem;
            @(posedge clk);
            // enable low: the request must wait
            #1 check("frozen", busy, 0);
            ce = 1;
            @(posedge clk);
            #1 req_v = 0;
            check("busy", busy, 1);
            for (int k = 0; k < 2000 && m_done !== 1'b1; k++) @(negedge clk);
            check("done", m_done, 1);
            check("idle", busy, 0);
            check("ex32 sample", m_ex32, x32);
            check("mio", seen_mio, exp_mio);
            check("wr", seen_wr, req.write);
            check("start low edges", low_cnt[7:0], 1);
            check("cycle length", oe_cnt[7:0], 8'(4 + w));
            $display("master test %0d ended", i);
        end
        for (int j = 0; j < 8; j++) begin
            wide = $urandom;
            rdy_cnt = 0;
            acc = 0;
            repeat (100) @(posedge clk);
            fork
                u_eisa_bus_partner.drive_cycle(j % 4 == 2, j[0], j % 4 != 3);
                for (int k = 0; k < 400 && acc == 0; k++) begin
                    @(negedge clk);
                    if (s_acc === 1'b1) begin
                        {acc, got_w, got_x} = {32'd1, s_wr, x_oe};
                        @(posedge clk);
                        #1 s_done = 1;
                        @(posedge clk);
                        #1 s_done = 0;
                    end
                end
            join
            w = (j % 4 < 2) ? 1 : 0;
            check("slave access", acc[7:0], w[7:0]);
            check("ready held", 8'(rdy_cnt > 0), w[7:0]);
            if (w == 1) begin
                check("slave write", got_w, j[0]);
                check("ex32 drive", got_x, wide);
            end
            $display("slave test %0d ended", j);
        end
        stop_test();
    end
endmodule
